// ==== ufcam_defines.vh ====
// Register map, field positions, reset values and bit timing of the serial port
`ifndef UFCAM_DEFINES_VH
`define UFCAM_DEFINES_VH
// Notes on behaviour
// - Modes 1 to 3 are full duplex; modes 1 and 3 have independent send and receive rates.
// - Framing checks run in all asynchronous modes only while enabled.
// - With checks on, an invalid stop bit sets the framing error flag.
// - Framing error flag stays set until software clear or reset.
// - With checks on, the receive flag rises at the stop bit.
// - Setting the multiprocessor enable bit turns on address recognition.
// - With recognition on, only frames for our addresses raise the flag.
// - In 8-bit mode the stop bit is the ninth bit when checks or recognition are on, and with recognition on must be valid.
// - Shift-register mode ignores the multiprocessor enable bit.
// - Given address compares slave address bits where mask bit is one.
// - Broadcast address is address OR mask, zero bits don't-care.
// - With checks on, control bit 7 is the framing error flag.
`define UFCAM_OFS_SCTRL 8'h00
`define UFCAM_OFS_DATA 8'h04
`define UFCAM_OFS_PCTRL 8'h08
`define UFCAM_OFS_SLAVE_ADDR 8'h0c
`define UFCAM_OFS_SMASK 8'h10
`define UFCAM_OFS_TXDIV 8'h14
`define UFCAM_OFS_RXDIV 8'h18
`define UFCAM_OFS_ISTAT 8'h1c
`define UFCAM_OFS_IMASK 8'h20
`define UFCAM_SC_FE_SM0 7
`define UFCAM_SC_SM1 6
`define UFCAM_SC_MP 5
`define UFCAM_SC_REN 4
`define UFCAM_SC_TB8 3
`define UFCAM_SC_RB8 2
`define UFCAM_SC_TI 1
`define UFCAM_SC_RI 0
`define UFCAM_PC_DBL 7
`define UFCAM_PC_FCE 6
`define UFCAM_IS_RX 0
`define UFCAM_IS_TX 1
`define UFCAM_IS_FE 2
`define UFCAM_IS_BUSY 7
`define UFCAM_RST_BYTE 8'h00
`define UFCAM_RST_IRQ 3'h0
`define UFCAM_RST_DIV 16'h01b2
`define UFCAM_M0_DIV 16'h000c
`define UFCAM_M2_DIV 16'h0040
`define UFCAM_M2_DIV_DBL 16'h0020
`define UFCAM_MODE_SHIFT 2'h0
`define UFCAM_MODE_8BIT 2'h1
`define UFCAM_MODE_FIX9 2'h2
`endif

// ==== ufcam_rx.v ====
// Serial receiver with stop bit check and slave address filter
`timescale 1ns/1ps
`default_nettype none
`include "ufcam_defines.vh"
module ufcam_rx #(
	parameter DIV_W = 16 // Bit period counter width
)(
	input wire clk_i, // Clock
	input wire rst_i, // Synchronous reset
	input wire rxd_i, // Serial data in
	input wire [1:0] mode_i, // Serial mode
	input wire [DIV_W-1:0] per_i, // Cycles per bit
	input wire ren_i, // Reception enable
	input wire mp_en_i, // multiproc_enable
	input wire fce_i, // framing_check_enable
	input wire rflag_i, // receive_flag state
	input wire [7:0] slave_addr_i, // slave_addr
	input wire [7:0] smask_i, // slave_addr_mask
	output wire done_o, // Accepted frame pulse
	output wire ferr_o, // Invalid stop bit pulse
	output wire sclk_o, // Shift clock in mode 0
	output wire [7:0] data_o, // Received byte
	output wire bit9_o // ninth_rx_bit of accepted frame
);
localparam S_IDLE = 3'd0;
localparam S_START = 3'd1;
localparam S_DATA = 3'd2;
localparam S_NINTH = 3'd3;
localparam S_STOP = 3'd4;
localparam S_SHIFT = 3'd5;
reg [2:0] st_ff;
reg [DIV_W-1:0] cnt_ff;
reg [2:0] bit_ff;
reg [7:0] sh_ff;
reg b9_ff;
reg prev_ff;
reg done_ff;
reg ferr_ff;
reg sclk_ff;
reg [7:0] data_ff;
reg nine_ff;
function hit;
	input [7:0] b;
	input [7:0] a;
	input [7:0] m;
	begin
		hit = ((b ^ a) & m) == 8'h00;
	end
endfunction
function take;
	input mp;
	input nine;
	input [7:0] b;
	input [7:0] a;
	input [7:0] m;
	begin
		take = !mp | (nine & (hit(b, a, m) | hit(b, a | m, a | m)));
	end
endfunction
wire tick = cnt_ff == {DIV_W{1'b0}};
// Minus one: the reload edge itself counts as a cycle
wire [DIV_W-1:0] half = (per_i >> 1) - 1'b1;
wire [DIV_W-1:0] full = per_i - 1'b1;
wire mp_act = mp_en_i & (mode_i != `UFCAM_MODE_SHIFT);
wire late = fce_i | (mp_act & (mode_i == `UFCAM_MODE_8BIT));
wire [7:0] byte_in = {rxd_i, sh_ff[7:1]};
wire nine_now = (st_ff == S_STOP && mode_i[1]) ? b9_ff : rxd_i;
wire acc = take(mp_act, nine_now, sh_ff, slave_addr_i, smask_i);
assign done_o = done_ff;
assign ferr_o = ferr_ff;
assign sclk_o = sclk_ff;
assign data_o = data_ff;
assign bit9_o = nine_ff;
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		st_ff <= S_IDLE;
		cnt_ff <= {DIV_W{1'b0}};
		bit_ff <= 3'd0;
		sh_ff <= `UFCAM_RST_BYTE;
		b9_ff <= 1'b0;
		prev_ff <= 1'b1;
		done_ff <= 1'b0;
		ferr_ff <= 1'b0;
		sclk_ff <= 1'b1;
		data_ff <= `UFCAM_RST_BYTE;
		nine_ff <= 1'b0;
	end
	else
	begin
		done_ff <= 1'b0;
		ferr_ff <= 1'b0;
		prev_ff <= rxd_i;
		if (!tick)
			cnt_ff <= cnt_ff - 1'b1;
		case (st_ff)
		S_IDLE:
		begin
			sclk_ff <= 1'b1;
			bit_ff <= 3'd0;
			// Guard cycle: the flag is set one edge after done
			if (mode_i == `UFCAM_MODE_SHIFT)
			begin
				if (ren_i && !rflag_i && !done_ff)
				begin
					st_ff <= S_SHIFT;
					sclk_ff <= 1'b0;
					cnt_ff <= half;
				end
			end
			else if (ren_i && prev_ff && !rxd_i)
			begin
				st_ff <= S_START;
				cnt_ff <= half;
			end
		end
		S_START:
			if (tick)
			begin
				// Glitch shorter than half a bit is no start
				st_ff <= rxd_i ? S_IDLE : S_DATA;
				cnt_ff <= full;
			end
		S_DATA:
			if (tick)
			begin
				sh_ff <= byte_in;
				bit_ff <= bit_ff + 1'b1;
				cnt_ff <= full;
				if (bit_ff == 3'd7)
				begin
					st_ff <= mode_i[1] ? S_NINTH : S_STOP;
					if (!mode_i[1] && !late)
					begin
						done_ff <= 1'b1;
						data_ff <= byte_in;
					end
				end
			end
		S_NINTH:
			if (tick)
			begin
				b9_ff <= rxd_i;
				st_ff <= S_STOP;
				cnt_ff <= full;
				if (!late)
				begin
					done_ff <= acc;
					if (acc)
					begin
						data_ff <= sh_ff;
						nine_ff <= rxd_i;
					end
				end
			end
		S_STOP:
			if (tick)
			begin
				st_ff <= S_IDLE;
				ferr_ff <= fce_i & !rxd_i;
				if (late)
				begin
					done_ff <= acc;
					if (acc)
					begin
						data_ff <= sh_ff;
						nine_ff <= nine_now;
					end
				end
			end
		S_SHIFT:
			if (tick)
			begin
				cnt_ff <= half;
				sclk_ff <= !sclk_ff;
				if (!sclk_ff)
				begin
					sh_ff <= byte_in;
					bit_ff <= bit_ff + 1'b1;
					if (bit_ff == 3'd7)
					begin
						st_ff <= S_IDLE;
						done_ff <= 1'b1;
						data_ff <= byte_in;
					end
				end
			end
		default:
			st_ff <= S_IDLE;
		endcase
	end
end
endmodule // ufcam_rx
`default_nettype wire

// ==== ufcam_top.v ====
// Serial port with framing check, address match and Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "ufcam_defines.vh"
module ufcam_top #(
	parameter DIV_W = 16, // Bit period counter width
	parameter [DIV_W-1:0] RST_DIV = `UFCAM_RST_DIV // Reset bit period
)(
	input wire clk_i, // Clock, 250 MHz
	input wire rst_i, // Synchronous reset, active high
	input wire wb_cyc_i, // Wishbone cycle
	input wire wb_stb_i, // Wishbone strobe
	input wire wb_we_i, // Wishbone write enable
	input wire [7:0] wb_adr_i, // Wishbone byte address
	input wire [3:0] wb_sel_i, // Wishbone byte lanes
	input wire [31:0] wb_dat_i, // Wishbone write data
	output wire [31:0] wb_dat_o, // Wishbone read data
	output wire wb_ack_o, // Wishbone acknowledge
	input wire rxd_i, // Serial data in
	output wire txd_o, // Serial data out
	output wire sclk_o, // Shift clock in mode 0
	output wire irq_o // Interrupt, active high level
);
localparam T_IDLE = 3'd0;
localparam T_START = 3'd1;
localparam T_DATA = 3'd2;
localparam T_NINTH = 3'd3;
localparam T_STOP = 3'd4;
localparam T_SHIFT = 3'd5;
reg ack_ff;
reg [31:0] dat_ff;
reg irq_ff;
reg txd_ff;
reg sclk_ff;
reg sm0_ff;
reg sm1_ff;
reg mp_ff;
reg ren_ff;
reg tb8_ff;
reg rb8_ff;
reg ti_ff;
reg ri_ff;
reg fe_ff;
reg dbl_ff;
reg fce_ff;
reg [7:0] rxbuf_ff;
reg [7:0] slave_addr_ff;
reg [7:0] smask_ff;
reg [DIV_W-1:0] txdiv_ff;
reg [DIV_W-1:0] rxdiv_ff;
reg [2:0] ist_ff;
reg [2:0] imask_ff;
reg [2:0] tst_ff;
reg [DIV_W-1:0] tcnt_ff;
reg [2:0] tbit_ff;
reg [7:0] tsh_ff;
reg tb9_ff;
reg tdone_ff;
reg tsclk_ff;
reg [31:0] nxt_dat;
reg nxt_ri;
reg nxt_ti;
reg nxt_fe;
reg [2:0] nxt_ist;
wire rx_done;
wire rx_ferr;
wire rx_sclk;
wire [7:0] rx_data;
wire rx_bit9;
function [DIV_W-1:0] period;
	input [1:0] md;
	input dbl;
	input [DIV_W-1:0] r;
	begin
		case (md)
		`UFCAM_MODE_SHIFT: period = `UFCAM_M0_DIV;
		`UFCAM_MODE_FIX9: period = dbl ? `UFCAM_M2_DIV_DBL : `UFCAM_M2_DIV;
		default: period = r;
		endcase
	end
endfunction
wire [1:0] mode = {sm0_ff, sm1_ff};
// Separate divisors keep the two directions at their own rates
wire [DIV_W-1:0] tper = period(mode, dbl_ff, txdiv_ff);
wire [DIV_W-1:0] rper = period(mode, dbl_ff, rxdiv_ff);
wire [DIV_W-1:0] tfull = tper - 1'b1;
wire [DIV_W-1:0] thalf = (tper >> 1) - 1'b1;
wire ttick = tcnt_ff == {DIV_W{1'b0}};
wire tbusy = tst_ff != T_IDLE;
wire req = wb_cyc_i & wb_stb_i;
// Writes commit on the edge where the master samples ack
wire wr = req & wb_we_i & ack_ff & wb_sel_i[0];
wire wr_hi = req & wb_we_i & ack_ff & wb_sel_i[1];
wire [7:0] d = wb_dat_i[7:0];
wire [7:0] dh = wb_dat_i[15:8];
wire w_sc = wr & (wb_adr_i == `UFCAM_OFS_SCTRL);
wire w_dt = wr & (wb_adr_i == `UFCAM_OFS_DATA);
wire w_pc = wr & (wb_adr_i == `UFCAM_OFS_PCTRL);
wire w_sa = wr & (wb_adr_i == `UFCAM_OFS_SLAVE_ADDR);
wire w_sm = wr & (wb_adr_i == `UFCAM_OFS_SMASK);
wire w_is = wr & (wb_adr_i == `UFCAM_OFS_ISTAT);
wire w_im = wr & (wb_adr_i == `UFCAM_OFS_IMASK);
wire w_td = wb_adr_i == `UFCAM_OFS_TXDIV;
wire w_rd = wb_adr_i == `UFCAM_OFS_RXDIV;
wire tx_go = w_dt & !tbusy;
wire [7:0] sc_rd = {fce_ff ? fe_ff : sm0_ff, sm1_ff, mp_ff, ren_ff,
	tb8_ff, rb8_ff, ti_ff, ri_ff};
assign wb_ack_o = ack_ff;
assign wb_dat_o = dat_ff;
assign irq_o = irq_ff;
assign txd_o = txd_ff;
assign sclk_o = sclk_ff;
ufcam_rx #(
	.DIV_W(DIV_W)
) u_rx (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.rxd_i(rxd_i),
	.mode_i(mode),
	.per_i(rper),
	.ren_i(ren_ff),
	.mp_en_i(mp_ff),
	.fce_i(fce_ff),
	.rflag_i(ri_ff),
	.slave_addr_i(slave_addr_ff),
	.smask_i(smask_ff),
	.done_o(rx_done),
	.ferr_o(rx_ferr),
	.sclk_o(rx_sclk),
	.data_o(rx_data),
	.bit9_o(rx_bit9)
);
always @*
begin
	nxt_dat = 32'h00000000;
	case (wb_adr_i)
	`UFCAM_OFS_SCTRL: nxt_dat[7:0] = sc_rd;
	`UFCAM_OFS_DATA: nxt_dat[7:0] = rxbuf_ff;
	`UFCAM_OFS_PCTRL:
	begin
		nxt_dat[`UFCAM_PC_DBL] = dbl_ff;
		nxt_dat[`UFCAM_PC_FCE] = fce_ff;
	end
	`UFCAM_OFS_SLAVE_ADDR: nxt_dat[7:0] = slave_addr_ff;
	`UFCAM_OFS_SMASK: nxt_dat[7:0] = smask_ff;
	`UFCAM_OFS_TXDIV: nxt_dat[DIV_W-1:0] = txdiv_ff;
	`UFCAM_OFS_RXDIV: nxt_dat[DIV_W-1:0] = rxdiv_ff;
	`UFCAM_OFS_ISTAT:
	begin
		nxt_dat[2:0] = ist_ff;
		nxt_dat[`UFCAM_IS_BUSY] = tbusy;
	end
	`UFCAM_OFS_IMASK: nxt_dat[2:0] = imask_ff;
	default: nxt_dat = 32'h00000000;
	endcase
end
// Hardware set wins over a software clear in the same cycle
always @*
begin
	nxt_ri = rx_done | (w_sc ? d[`UFCAM_SC_RI] : ri_ff);
	nxt_ti = tdone_ff | (w_sc ? d[`UFCAM_SC_TI] : ti_ff);
	nxt_fe = rx_ferr | ((w_sc & fce_ff) ? d[`UFCAM_SC_FE_SM0] : fe_ff);
	nxt_ist = (ist_ff & ~(w_is ? d[2:0] : 3'h0))
		| {rx_ferr, tdone_ff, rx_done};
end
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		ack_ff <= 1'b0;
		dat_ff <= 32'h00000000;
		irq_ff <= 1'b0;
		sclk_ff <= 1'b1;
		sm0_ff <= 1'b0;
		sm1_ff <= 1'b0;
		mp_ff <= 1'b0;
		ren_ff <= 1'b0;
		tb8_ff <= 1'b0;
		rb8_ff <= 1'b0;
		ti_ff <= 1'b0;
		ri_ff <= 1'b0;
		fe_ff <= 1'b0;
		dbl_ff <= 1'b0;
		fce_ff <= 1'b0;
		rxbuf_ff <= `UFCAM_RST_BYTE;
		slave_addr_ff <= `UFCAM_RST_BYTE;
		smask_ff <= `UFCAM_RST_BYTE;
		txdiv_ff <= RST_DIV;
		rxdiv_ff <= RST_DIV;
		ist_ff <= `UFCAM_RST_IRQ;
		imask_ff <= `UFCAM_RST_IRQ;
	end
	else
	begin
		ack_ff <= req & !ack_ff;
		dat_ff <= nxt_dat;
		sclk_ff <= tsclk_ff & rx_sclk;
		ri_ff <= nxt_ri;
		ti_ff <= nxt_ti;
		fe_ff <= nxt_fe;
		ist_ff <= nxt_ist;
		irq_ff <= |(nxt_ist & imask_ff);
		if (rx_done)
		begin
			rxbuf_ff <= rx_data;
			rb8_ff <= rx_bit9;
		end
		else if (w_sc)
			rb8_ff <= d[`UFCAM_SC_RB8];
		if (w_sc)
		begin
			// Bit 7 holds the mode bit only while checks are off
			if (!fce_ff)
				sm0_ff <= d[`UFCAM_SC_FE_SM0];
			sm1_ff <= d[`UFCAM_SC_SM1];
			mp_ff <= d[`UFCAM_SC_MP];
			ren_ff <= d[`UFCAM_SC_REN];
			tb8_ff <= d[`UFCAM_SC_TB8];
		end
		if (w_pc)
		begin
			dbl_ff <= d[`UFCAM_PC_DBL];
			fce_ff <= d[`UFCAM_PC_FCE];
		end
		if (w_sa)
			slave_addr_ff <= d;
		if (w_sm)
			smask_ff <= d;
		if (w_im)
			imask_ff <= d[2:0];
		if (wr & w_td)
			txdiv_ff[7:0] <= d;
		if (wr_hi & w_td)
			txdiv_ff[DIV_W-1:8] <= dh;
		if (wr & w_rd)
			rxdiv_ff[7:0] <= d;
		if (wr_hi & w_rd)
			rxdiv_ff[DIV_W-1:8] <= dh;
	end
end
// A write to the data register while busy is dropped
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		tst_ff <= T_IDLE;
		tcnt_ff <= {DIV_W{1'b0}};
		tbit_ff <= 3'd0;
		tsh_ff <= `UFCAM_RST_BYTE;
		tb9_ff <= 1'b0;
		tdone_ff <= 1'b0;
		tsclk_ff <= 1'b1;
		txd_ff <= 1'b1;
	end
	else
	begin
		tdone_ff <= 1'b0;
		if (!ttick)
			tcnt_ff <= tcnt_ff - 1'b1;
		case (tst_ff)
		T_IDLE:
		begin
			tsclk_ff <= 1'b1;
			tbit_ff <= 3'd0;
			if (tx_go)
			begin
				tsh_ff <= d;
				tb9_ff <= tb8_ff;
				if (mode == `UFCAM_MODE_SHIFT)
				begin
					tst_ff <= T_SHIFT;
					txd_ff <= d[0];
					tsclk_ff <= 1'b0;
					tcnt_ff <= thalf;
				end
				else
				begin
					tst_ff <= T_START;
					txd_ff <= 1'b0;
					tcnt_ff <= tfull;
				end
			end
		end
		T_START:
			if (ttick)
			begin
				txd_ff <= tsh_ff[0];
				tst_ff <= T_DATA;
				tcnt_ff <= tfull;
			end
		T_DATA:
			if (ttick)
			begin
				tbit_ff <= tbit_ff + 1'b1;
				tcnt_ff <= tfull;
				tsh_ff <= tsh_ff >> 1;
				if (tbit_ff != 3'd7)
					txd_ff <= tsh_ff[1];
				else if (mode[1])
				begin
					txd_ff <= tb9_ff;
					tst_ff <= T_NINTH;
				end
				else
				begin
					txd_ff <= 1'b1;
					tst_ff <= T_STOP;
					tdone_ff <= 1'b1;
				end
			end
		T_NINTH:
			if (ttick)
			begin
				txd_ff <= 1'b1;
				tst_ff <= T_STOP;
				tcnt_ff <= tfull;
				tdone_ff <= 1'b1;
			end
		T_STOP:
			if (ttick)
				tst_ff <= T_IDLE;
		T_SHIFT:
			if (ttick)
			begin
				tcnt_ff <= thalf;
				tsclk_ff <= !tsclk_ff;
				if (!tsclk_ff)
				begin
					tbit_ff <= tbit_ff + 1'b1;
					if (tbit_ff == 3'd7)
					begin
						tst_ff <= T_IDLE;
						tdone_ff <= 1'b1;
						txd_ff <= 1'b1;
					end
				end
				else
				begin
					txd_ff <= tsh_ff[1];
					tsh_ff <= tsh_ff >> 1;
				end
			end
		default:
			tst_ff <= T_IDLE;
		endcase
	end
end
endmodule // ufcam_top
`default_nettype wire

// ==== ufcam_chk.sv ====
// Bus, reset, interrupt and shift clock checks bound to the serial port top
`timescale 1ns/1ps
`default_nettype none
module ufcam_chk (
	input wire clk_i, // Clock
	input wire rst_i, // Reset
	input wire wb_cyc_i, // Cycle
	input wire wb_stb_i, // Strobe
	input wire wb_we_i, // Write
	input wire [7:0] wb_adr_i, // Address
	input wire [3:0] wb_sel_i, // Lanes
	input wire [31:0] wb_dat_i, // Write data
	input wire [31:0] wb_dat_o, // Read data
	input wire wb_ack_o, // Ack
	input wire rxd_i, // Serial in
	input wire txd_o, // Serial out
	input wire sclk_o, // Shift clock
	input wire irq_o // Interrupt
);
	wire req = wb_cyc_i & wb_stb_i;
	wire rd = wb_ack_o & !wb_we_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_lat;
		req && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_ack_cause;
		wb_ack_o |-> $past(req);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack no req");
	property p_rst;
		disable iff (1'b0) rst_i |=> !wb_ack_o && txd_o && sclk_o && !irq_o;
	endproperty
	a_rst: assert property (p_rst) else $error("reset levels");
	property p_unmap;
		rd && wb_adr_i > 8'h20 |-> wb_dat_o == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_rd_width;
		rd |-> wb_dat_o[31:16] == 16'h0 && (wb_adr_i == 8'h14 ||
			wb_adr_i == 8'h18 || wb_dat_o[15:8] == 8'h00);
	endproperty
	a_rd_width: assert property (p_rd_width) else $error("read width");
	property p_irq_mask;
		wb_ack_o && wb_we_i && wb_adr_i == 8'h20 && wb_sel_i[0] &&
			wb_dat_i[2:0] == 3'h0 |=> ##1 !irq_o;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq not masked");
	// Mode 0 half period is fixed at 6 cycles
	property p_sclk_low;
		$fell(sclk_o) |=> !sclk_o[*5] ##1 sclk_o;
	endproperty
	a_sclk_low: assert property (p_sclk_low) else $error("shift clock");
endmodule // ufcam_chk
bind ufcam_top ufcam_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i),
	.txd_o(txd_o), .sclk_o(sclk_o), .irq_o(irq_o));
`default_nettype wire

// ==== ufcam_peer.sv ====
// Remote serial peer: sends frames on rxd and captures frames from txd
`timescale 1ns/1ps
`default_nettype none
module ufcam_peer #(
	parameter int P = 16 // Cycles per bit
)(
	input wire clk_i, // Clock
	input wire txd_i, // Line from the device
	input wire sclk_i, // Shift clock from the device
	output logic rxd_o // Line to the device, idles high
);
	initial rxd_o = 1'b1;
	// Start, n data bits LSB first, then the stop level given
	task automatic send(input logic [8:0] d, input int n, input logic stp);
		logic [10:0] f;
		f = {2'b11, d} << 1;
		f[n+1] = stp;
		for (int i = 0; i < n + 2; i++)
		begin
			@(posedge clk_i);
			rxd_o <= f[i];
			repeat (P - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		rxd_o <= 1'b1;
	endtask
	task automatic recv(output logic [7:0] d, output logic ok);
		int k;
		for (k = 0; k < 40 * P && txd_i; k++) @(posedge clk_i);
		ok = !txd_i;
		repeat (P + P / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++)
		begin
			d[i] = txd_i;
			repeat (P) @(posedge clk_i);
		end
	endtask
	// Next bit moves after the rising shift edge has sampled the last
	task automatic shift(input logic [7:0] d);
		int k;
		rxd_o <= d[0];
		for (int i = 1; i < 9; i++)
		begin
			for (k = 0; k < 64 && sclk_i; k++) @(posedge clk_i);
			for (k = 0; k < 64 && !sclk_i; k++) @(posedge clk_i);
			rxd_o <= (i < 8) ? d[i] : 1'b1;
		end
	endtask
endmodule // ufcam_peer
`default_nettype wire

// ==== tb_uart_frame_check_addr_match.sv ====
// Self-checking bench for the serial port with framing and address checks
`timescale 1ns/1ps
`default_nettype none
module tb_uart_frame_check_addr_match;
	localparam int P = 16;
	logic clk_i, rst_i, cyc, stb, we;
	logic [7:0] adr;
	logic [31:0] wdat;
	wire [31:0] rdat;
	wire ack, txd, sclk, irq, rxd;
	int err_count, checked;
	ufcam_top #(.RST_DIV(16'h0010)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rxd_i(rxd), .txd_o(txd), .sclk_o(sclk), .irq_o(irq));
	ufcam_peer #(.P(P)) peer (.clk_i(clk_i), .txd_i(txd), .sclk_i(sclk),
		.rxd_o(rxd));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] got, exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (k = 0; k < 50 && ack !== 1'b1; k++)
			@(posedge clk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 50)
		begin
			err_count++;
			finish_test;
		end
	endtask
	task automatic t_regs;
		logic [31:0] q;
		for (int a = 0; a <= 36; a += 4)
		begin
			bus(1'b0, a[7:0], 32'h0, q);
			chk("reset", q, (a == 20 || a == 24) ? 32'h10 : 32'h0);
		end
		bus(1'b1, 8'h24, 32'hff, q);
		bus(1'b0, 8'h24, 32'h0, q);
		chk("unmapped", q, 32'h0);
	endtask
	task automatic t_frame;
		logic [31:0] q;
		logic [7:0] d;
		logic ok;
		bus(1'b1, 8'h08, 32'h40, q);
		bus(1'b1, 8'h00, 32'h50, q);
		bus(1'b1, 8'h20, 32'h7, q);
		peer.send(9'h03c, 8, 1'b0);
		bus(1'b0, 8'h00, 32'h0, q);
		chk("fe set", q & 32'h80, 32'h80);
		bus(1'b0, 8'h1c, 32'h0, q);
		chk("fe irq", {q[2], irq}, 2'b11);
		fork
			peer.send(9'h0a5, 8, 1'b1);
			peer.recv(d, ok);
			bus(1'b1, 8'h04, 32'h5a, q);
		join
		chk("tx byte", {ok, d}, 9'h15a);
		bus(1'b0, 8'h04, 32'h0, q);
		chk("rx byte", q, 32'ha5);
		bus(1'b0, 8'h00, 32'h0, q);
		chk("fe kept", q & 32'h80, 32'h80);
		bus(1'b1, 8'h00, 32'h50, q);
		bus(1'b0, 8'h00, 32'h0, q);
		chk("fe clear", q & 32'h80, 32'h0);
		bus(1'b1, 8'h1c, 32'h7, q);
		bus(1'b1, 8'h08, 32'h0, q);
		peer.send(9'h03c, 8, 1'b0);
		bus(1'b0, 8'h1c, 32'h0, q);
		chk("fe off", q[2], 1'b0);
	endtask
	task automatic t_lat(input logic f);
		logic [31:0] q;
		logic in_win;
		int c;
		bus(1'b1, 8'h08, f ? 32'h40 : 32'h0, q);
		bus(1'b1, 8'h00, 32'h50, q);
		bus(1'b1, 8'h1c, 32'h7, q);
		bus(1'b1, 8'h20, 32'h1, q);
		fork
			peer.send(9'h055, 8, 1'b1);
			for (c = 0; irq !== 1'b1 && c < 20 * P; c++) @(posedge clk_i);
		join
		// Flag at last data bit, or one bit later at stop
		in_win = c >= (f ? 9 : 8) * P && c < (f ? 10 : 9) * P;
		chk("rx flag time", in_win, 1'b1);
	endtask
	// Entry: control byte, accept, 9-bit send, ninth or stop bit, address
	task automatic t_one(input logic [19:0] e);
		logic [31:0] q;
		bus(1'b1, 8'h00, {24'h0, e[19:12]}, q);
		bus(1'b1, 8'h1c, 32'h1, q);
		if (e[9])
			peer.send(e[8:0], 9, 1'b1);
		else
			peer.send({1'b0, e[7:0]}, 8, e[8]);
		bus(1'b0, 8'h1c, 32'h0, q);
		chk("accept", q[0], e[10]);
		bus(1'b0, 8'h04, 32'h0, q);
		if (e[10])
			chk("address", q, e[7:0]);
		bus(1'b0, 8'h00, 32'h0, q);
		if (e[10])
			chk("ninth bit", q[2], e[8]);
	endtask
	task automatic t_addr;
		logic [31:0] q;
		bus(1'b1, 8'h08, 32'h0, q);
		bus(1'b1, 8'h0c, 32'hf1, q);
		bus(1'b1, 8'h10, 32'hfa, q);
		t_one(20'hf07f0);
		t_one(20'hf07f1);
		t_one(20'hf03f3);
		t_one(20'hf07fb);
		t_one(20'hf07ff);
		t_one(20'hf02f0);
		t_one(20'hf07f4);
		t_one(20'hd06f3);
		t_one(20'h705f0);
		t_one(20'h700f0);
		t_one(20'h701f3);
		// Given address exact: every bit compared, broadcast address becomes ff
		bus(1'b1, 8'h10, 32'hff, q);
		t_one(20'hf07f1);
		t_one(20'hf03f0);
		bus(1'b1, 8'h20, 32'h0, q);
	endtask
	task automatic t_shift;
		logic [31:0] q;
		bus(1'b1, 8'h00, 32'h0, q);
		bus(1'b1, 8'h1c, 32'h7, q);
		fork
			peer.shift(8'h96);
			bus(1'b1, 8'h00, 32'h30, q);
		join
		q = 32'h0;
		for (int k = 0; k < 20 && !q[0]; k++)
			bus(1'b0, 8'h1c, 32'h0, q);
		bus(1'b0, 8'h04, 32'h0, q);
		chk("shift byte", q, 32'h96);
	endtask
	initial
	begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		finish_test;
	end
	initial
	begin
		{cyc, stb, we, adr, wdat} = '0;
		rst_i = 1'b1;
		err_count = 0;
		checked = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_frame;
		t_lat(1'b0);
		t_lat(1'b1);
		t_addr;
		t_shift;
		finish_test;
	end
endmodule // tb_uart_frame_check_addr_match
`default_nettype wire
